// ===== delay_counter.sv
// Tick-based delay counter with clear, run and threshold compare
`default_nettype none
module delay_counter #(
	parameter int W = 18 // Counter width
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic clear, // Restart count from zero
	input wire logic run, // Count on ticks while high
	input wire logic tick, // Shared timebase pulse
	input wire logic [W-1:0] limit, // Threshold in ticks
	output logic done // Count has reached the limit
);
	logic [W-1:0] count_reg; // Elapsed ticks
	logic [W-1:0] count_next; // Next elapsed ticks

	// Reached once the elapsed ticks meet the threshold
	assign done = (count_reg >= limit);

	// Next count: clear wins, then count up until done
	always_comb begin
		count_next = count_reg;
		if (clear) begin
			count_next = '0;
		end else if (run && tick && !done) begin
			count_next = count_reg + W'(1);
		end
	end

	// Count register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end
endmodule // delay_counter
`default_nettype wire

// ===== host_req_model.sv
// Host controller model driving the per-port request pins
`default_nettype none
module host_req_model (
	input wire logic pclk, // Clock
	input wire logic [3:0] sw_cmd, // Wanted switch levels
	input wire logic [3:0] rl_cmd, // Wanted relay levels
	output logic [3:0] switch_request, // Switch request pins
	output logic [3:0] relay_request // Relay request pins
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pins start released low, then follow the commands at each edge
	initial begin
		switch_request = 4'h0;
		relay_request = 4'h0;
		// Both requests may move together; the device spaces them
		forever @(posedge pclk) begin
			switch_request <= sw_cmd;
			relay_request <= rl_cmd;
		end
	end
endmodule // host_req_model
`default_nettype wire

// ===== power_seq_pkg.sv
// Shared constants and types for the four-port power switch sequencer
`default_nettype none
package power_seq_pkg;
	// Channel count and clock
	localparam int NUM_CH = 4; // Independent power ports
	localparam int CLK_PERIOD_NS = 10; // 100 MHz pclk
	// Shared timebase: one tick every 100 us
	localparam int TICK_NS = 100000; // Tick period in ns
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS; // Cycles per tick
	localparam int TICK_US = 100; // Tick period in us
	localparam int TIMER_W = 18; // Delay counter width in ticks
	// Delay figures in microseconds
	localparam int SUPPLY_DEGLITCH_US = 25600; // 25.6 ms above lockout
	localparam int RELAY_SETTLE_US = 25600; // 25.6 ms relay close time
	localparam int RELAY_OFF_US = 3200; // 3.2 ms relay release delay
	localparam int OC_BASE_US = 6400; // 6.4 ms at the 2 kohm step
	localparam int OPEN_ARM_US = 900000; // 900 ms after power good
	localparam int OPEN_DELAY_US = 25600; // 25.6 ms open-circuit delay
	// Delays in ticks, least times rounded up
	localparam logic [TIMER_W-1:0] SUPPLY_DEGLITCH_TICKS =
		TIMER_W'((SUPPLY_DEGLITCH_US + TICK_US - 1) / TICK_US);
	localparam logic [TIMER_W-1:0] RELAY_SETTLE_TICKS =
		TIMER_W'((RELAY_SETTLE_US + TICK_US - 1) / TICK_US);
	localparam logic [TIMER_W-1:0] RELAY_OFF_TICKS =
		TIMER_W'((RELAY_OFF_US + TICK_US - 1) / TICK_US);
	localparam logic [TIMER_W-1:0] OC_BASE_TICKS =
		TIMER_W'((OC_BASE_US + TICK_US - 1) / TICK_US);
	localparam logic [TIMER_W-1:0] OPEN_ARM_TICKS =
		TIMER_W'((OPEN_ARM_US + TICK_US - 1) / TICK_US);
	localparam logic [TIMER_W-1:0] OPEN_DELAY_TICKS =
		TIMER_W'((OPEN_DELAY_US + TICK_US - 1) / TICK_US);
	// Off-time multiples of the overcurrent limit: (100 - d) / d
	localparam logic [TIMER_W-1:0] DUTY_MULT_1PCT = 18'h00063; // 99
	localparam logic [TIMER_W-1:0] DUTY_MULT_2PCT = 18'h00031; // 49
	localparam logic [TIMER_W-1:0] DUTY_MULT_4PCT = 18'h00018; // 24
	// Register map (byte addresses)
	localparam int ADDR_W = 8; // Decoded address bits
	localparam logic [ADDR_W-1:0] ADDR_TIMING = 8'h00; // Timing resistor
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04; // Port status
	// Timing register: resistor in 2 kohm steps, zero means unconnected
	localparam int RATIO_W = 5; // Field width
	localparam logic [RATIO_W-1:0] RATIO_RESET = 5'h00; // Unconnected
	localparam logic [RATIO_W-1:0] RATIO_MIN = 5'h01; // 2 kohm
	localparam logic [RATIO_W-1:0] RATIO_MAX = 5'h14; // 40 kohm
	// Status register field positions
	localparam int STAT_PG_LSB = 0; // Power good per port
	localparam int STAT_OPEN_LSB = 4; // Open-circuit flag per port
	localparam int STAT_OC_LSB = 8; // Overcurrent latch per port
	localparam int STAT_RELAY_LSB = 12; // Relay drive per port
	localparam int STAT_GATE_LSB = 16; // Gate drive per port
	localparam int STAT_SUPPLY_BIT = 20; // Supply qualified
	// Channel sequencing states, one-hot
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01, // Relay and switch off
		ST_RELAY_WAIT = 8'h02, // Relay closing, switch held off
		ST_READY = 8'h04, // Relay closed, switch off
		ST_ON = 8'h08, // Gate driven
		ST_RETRY_WAIT = 8'h10, // Off time after overcurrent
		ST_LATCHED_OC = 8'h20, // Latched off by overcurrent
		ST_LATCHED_OPEN = 8'h40, // Latched off by open circuit
		ST_RELAY_OFF_WAIT = 8'h80 // Switch off, relay releasing
	} ch_state_t;
endpackage
`default_nettype wire

// ===== quad_port_power_switch_sequencer.sv
// Four-port relay and switch sequencer with lockout, retry and status
//
// Behaviour
// - Gate on only with switch and relay requests
// - Switch needs supply qualified above 25.6 ms
// - Relay on at once, switch held 25.6 ms
// - Relay request low: switch off, relay later
// - Switch request falling edge clears overcurrent latch
// - Switch request low clears open-circuit latch
// - Retry enable picks auto-retry or latch-off
// - Duty select low/high/float gives 1/2/4 %
// - Overcurrent trip waits full off time unless relay release or lockout cuts it
// - Current limit past time limit trips switch
// - Auto-retry restarts switch after off time
// - Time limit 6.4 ms when resistor unconnected
// - Open detection armed 900 ms after power good
// - Status shows power good or open flag
// - Supply lockout holds everything off, with hysteresis
// - Power good needs fully on, not limiting
// - Fault low on open, retry or latch
// - Low current 25.6 ms turns switch off, flags
// - Time limit scales with resistor over 2 kohm
// - Open flag high only while latched open
`default_nettype none
module quad_port_power_switch_sequencer #(
	parameter int TICK_CYCLES = power_seq_pkg::TICK_CYCLES // Cycles per tick
) (
	input wire logic pclk, // System clock, 100 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic [power_seq_pkg::ADDR_W-1:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [3:0] switch_request, // Per-port switch request pins
	input wire logic [3:0] relay_request, // Per-port relay request pins
	input wire logic [3:0] switch_full_on, // Switch drop below 1.5 V
	input wire logic [3:0] in_current_limit, // Current limit comparator
	input wire logic [3:0] below_open_current, // Open-current comparator
	input wire logic supply_above_on, // Supply above lockout threshold
	input wire logic supply_above_off, // Supply above threshold less hyst
	input wire logic open_detect_enable, // Open detection enable pin
	input wire logic status_select, // Status mux select pin
	input wire logic retry_enable, // Auto-retry enable pin
	input wire logic duty_select_high, // Duty pin reads high
	input wire logic duty_select_low, // Duty pin reads low
	output logic [3:0] gate_drive, // Per-port gate drive enable
	output logic [3:0] relay_drive, // Per-port relay driver enable
	output logic [3:0] port_status, // Multiplexed per-port status
	output logic fault_n_out, // Open-drain fault level, always low
	output logic fault_n_oe // Fault pulled low while high
);
	localparam int N = power_seq_pkg::NUM_CH; // Channel count
	localparam int TW = power_seq_pkg::TIMER_W; // Timer width
	localparam int SYNC_W = 5 * N + 7; // Synchronised pin count
	localparam int TICK_W = $clog2(TICK_CYCLES); // Tick divider width

	// Clamp the resistor code; zero means the internal default
	function automatic logic [power_seq_pkg::RATIO_W-1:0] clamp_ratio(
		input logic [power_seq_pkg::RATIO_W-1:0] code);
		logic [power_seq_pkg::RATIO_W-1:0] r;
		r = code;
		if (code == power_seq_pkg::RATIO_RESET) begin
			r = power_seq_pkg::RATIO_MIN;
		end else if (code > power_seq_pkg::RATIO_MAX) begin
			r = power_seq_pkg::RATIO_MAX;
		end
		return r;
	endfunction

	// Three-level duty pin to off-time multiple
	function automatic logic [TW-1:0] duty_mult(input logic hi,
		input logic lo);
		logic [TW-1:0] m;
		m = power_seq_pkg::DUTY_MULT_4PCT;
		if (lo) begin
			m = power_seq_pkg::DUTY_MULT_1PCT;
		end else if (hi) begin
			m = power_seq_pkg::DUTY_MULT_2PCT;
		end
		return m;
	endfunction

	// Pin synchronisers
	logic [SYNC_W-1:0] pins_raw; // All asynchronous pins
	logic [SYNC_W-1:0] sync1_reg; // First stage, read only by stage two
	logic [SYNC_W-1:0] sync2_reg; // Synchronised pins
	assign pins_raw = {switch_request, relay_request, switch_full_on,
		in_current_limit, below_open_current, supply_above_on,
		supply_above_off, open_detect_enable, status_select,
		retry_enable, duty_select_high, duty_select_low};

	// Two-flop synchroniser for every pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
		end
	end

	logic [N-1:0] sw_s; // Switch requests
	logic [N-1:0] rly_s; // Relay requests
	logic [N-1:0] full_on_s; // Fully-on comparators
	logic [N-1:0] limit_s; // Current-limit comparators
	logic [N-1:0] open_cur_s; // Open-current comparators
	logic above_on_s; // Above lockout threshold
	logic above_off_s; // Above threshold less hysteresis
	logic ode_s; // Open detect enable
	logic stsel_s; // Status select
	logic retry_s; // Retry enable
	logic duty_hi_s; // Duty pin high
	logic duty_lo_s; // Duty pin low
	assign {sw_s, rly_s, full_on_s, limit_s, open_cur_s, above_on_s,
		above_off_s, ode_s, stsel_s, retry_s, duty_hi_s,
		duty_lo_s} = sync2_reg;

	// Shared timebase
	logic [TICK_W-1:0] tick_cnt_reg; // Cycle divider
	logic [TICK_W-1:0] tick_cnt_next; // Next divider value
	logic tick; // One-cycle pulse per tick

	// One tick shared by all four channels
	always_comb begin
		tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
		tick_cnt_next = tick ? '0 : tick_cnt_reg + TICK_W'(1);
	end

	// Divider register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
		end
	end

	// Supply lockout with hysteresis and deglitch
	logic supply_above_reg; // Supply past lockout, held by hysteresis
	logic supply_above_next; // Next lockout state
	logic supply_timer_done; // Above threshold long enough
	logic supply_up; // Switches may turn on

	// Set above threshold, drop below threshold less hysteresis
	always_comb begin
		supply_above_next = supply_above_reg;
		if (above_on_s) begin
			supply_above_next = 1'b1;
		end else if (!above_off_s) begin
			supply_above_next = 1'b0;
		end
	end

	// Lockout register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supply_above_reg <= 1'b0;
		end else begin
			supply_above_reg <= supply_above_next;
		end
	end

	// A dip below the threshold less hysteresis restarts the deglitch interval
	delay_counter #(.W(TW)) u_supply_timer (
		.pclk(pclk),
		.presetn(presetn),
		.clear(!supply_above_reg),
		.run(1'b1),
		.tick(tick),
		.limit(power_seq_pkg::SUPPLY_DEGLITCH_TICKS),
		.done(supply_timer_done)
	);
	assign supply_up = supply_above_reg && supply_timer_done;

	// Register file and timing derived from it
	logic [power_seq_pkg::RATIO_W-1:0] timing_reg; // Timing resistor code
	logic [power_seq_pkg::RATIO_W-1:0] timing_next; // Next resistor code
	logic [31:0] prdata_reg; // Read data, captured in setup phase
	logic [31:0] prdata_next; // Next read data
	logic [31:0] status_word; // Live status view
	logic [TW-1:0] limit_ticks; // Overcurrent time limit
	logic [TW-1:0] off_ticks; // Retry off time
	logic mapped; // Address hits a register

	// Time limit is the base step times resistor over 2 kohm
	always_comb begin
		limit_ticks = TW'(power_seq_pkg::OC_BASE_TICKS *
			TW'(clamp_ratio(timing_reg)));
		off_ticks = TW'(limit_ticks * duty_mult(duty_hi_s,
			duty_lo_s));
	end

	// Decode, write and read-data capture
	always_comb begin
		mapped = (paddr == power_seq_pkg::ADDR_TIMING) ||
			(paddr == power_seq_pkg::ADDR_STATUS);
		timing_next = timing_reg;
		if (psel && penable && pwrite &&
			paddr == power_seq_pkg::ADDR_TIMING) begin
			timing_next = pwdata[power_seq_pkg::RATIO_W-1:0];
		end
		prdata_next = prdata_reg;
		if (psel && !penable) begin
			case (paddr)
				power_seq_pkg::ADDR_TIMING: begin
					prdata_next = 32'(timing_reg);
				end
				power_seq_pkg::ADDR_STATUS: begin
					prdata_next = status_word;
				end
				default: begin
					prdata_next = '0;
				end
			endcase
		end
	end

	// Register file flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timing_reg <= power_seq_pkg::RATIO_RESET;
			prdata_reg <= '0;
		end else begin
			timing_reg <= timing_next;
			prdata_reg <= prdata_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Per-channel sequencing
	logic [N-1:0] gate_next; // Next gate drive
	logic [N-1:0] relay_next; // Next relay drive
	logic [N-1:0] pg_next; // Next power good
	logic [N-1:0] open_next; // Next open flag
	logic [N-1:0] faulted_next; // Channel asks for fault
	logic [N-1:0] pg_reg; // Power good
	logic [N-1:0] open_reg; // Open flag
	logic [N-1:0] oc_latch_reg; // Overcurrent latch, for status

	genvar ch;
	generate
		for (ch = 0; ch < N; ch++) begin : g_ch
			power_seq_pkg::ch_state_t state_reg; // Channel state
			power_seq_pkg::ch_state_t state_next; // Next channel state
			logic latch_reg; // Overcurrent latch-off held
			logic latch_next; // Next latch
			logic sw_prev_reg; // Switch request last cycle
			logic [TW-1:0] st_limit; // Limit of the state timer
			logic st_done; // State delay elapsed
			logic oc_done; // Limiting past the time limit
			logic armed; // Open detection armed
			logic open_done; // Low current past the delay
			logic sw_fall; // Switch request falling edge
			logic oc_trip; // Overcurrent trip this cycle

			// Next state, latch and outputs for this channel
			always_comb begin
				sw_fall = sw_prev_reg && !sw_s[ch];
				oc_trip = (state_reg == power_seq_pkg::ST_ON) &&
					oc_done;
				latch_next = latch_reg;
				if (oc_trip && !retry_s) begin
					latch_next = 1'b1;
				end else if (sw_fall) begin
					latch_next = 1'b0;
				end
				state_next = state_reg;
				case (state_reg)
					power_seq_pkg::ST_IDLE: begin
						if (rly_s[ch]) begin
							state_next = power_seq_pkg::ST_RELAY_WAIT;
						end
					end
					power_seq_pkg::ST_RELAY_WAIT: begin
						if (st_done) begin
							state_next = power_seq_pkg::ST_READY;
						end
					end
					power_seq_pkg::ST_READY: begin
						if (sw_s[ch] && supply_up && !latch_reg) begin
							state_next = power_seq_pkg::ST_ON;
						end
					end
					power_seq_pkg::ST_ON: begin
						if (oc_trip) begin
							state_next = power_seq_pkg::ST_RETRY_WAIT;
						end else if (open_done) begin
							state_next = power_seq_pkg::ST_LATCHED_OPEN;
						end else if (!sw_s[ch] || !supply_up) begin
							state_next = power_seq_pkg::ST_READY;
						end
					end
					power_seq_pkg::ST_RETRY_WAIT: begin
						if (st_done) begin
							state_next = latch_next ?
								power_seq_pkg::ST_LATCHED_OC :
								power_seq_pkg::ST_READY;
						end
					end
					power_seq_pkg::ST_LATCHED_OC: begin
						if (!latch_reg) begin
							state_next = power_seq_pkg::ST_READY;
						end
					end
					power_seq_pkg::ST_LATCHED_OPEN: begin
						if (!sw_s[ch]) begin
							state_next = power_seq_pkg::ST_READY;
						end
					end
					power_seq_pkg::ST_RELAY_OFF_WAIT: begin
						if (st_done) begin
							state_next = power_seq_pkg::ST_IDLE;
						end
					end
					default: begin
						state_next = power_seq_pkg::ST_IDLE;
					end
				endcase
				// Lockout and relay release override the sequence
				if (!supply_above_reg) begin
					state_next = power_seq_pkg::ST_IDLE;
				end else if (!rly_s[ch] &&
					state_reg != power_seq_pkg::ST_IDLE &&
					state_reg != power_seq_pkg::ST_RELAY_OFF_WAIT) begin
					state_next = power_seq_pkg::ST_RELAY_OFF_WAIT;
				end
				// State timer limit follows the current state
				case (state_reg)
					power_seq_pkg::ST_RETRY_WAIT: begin
						st_limit = off_ticks;
					end
					power_seq_pkg::ST_RELAY_OFF_WAIT: begin
						st_limit = power_seq_pkg::RELAY_OFF_TICKS;
					end
					default: begin
						st_limit = power_seq_pkg::RELAY_SETTLE_TICKS;
					end
				endcase
				gate_next[ch] = (state_next == power_seq_pkg::ST_ON) &&
					sw_s[ch] && rly_s[ch];
				relay_next[ch] = (state_next != power_seq_pkg::ST_IDLE);
				pg_next[ch] = gate_next[ch] && full_on_s[ch] &&
					!limit_s[ch];
				open_next[ch] =
					(state_next == power_seq_pkg::ST_LATCHED_OPEN);
				faulted_next[ch] = latch_next ||
					(state_next == power_seq_pkg::ST_RETRY_WAIT) ||
					(state_next == power_seq_pkg::ST_LATCHED_OC) ||
					(state_next == power_seq_pkg::ST_LATCHED_OPEN);
			end

			// Channel state flops
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					state_reg <= power_seq_pkg::ST_IDLE;
					latch_reg <= 1'b0;
					sw_prev_reg <= 1'b0;
				end else begin
					state_reg <= state_next;
					latch_reg <= latch_next;
					sw_prev_reg <= sw_s[ch];
				end
			end

			// Own state timer, restarted on every state change
			delay_counter #(.W(TW)) u_state_timer (
				.pclk(pclk),
				.presetn(presetn),
				.clear(state_next != state_reg),
				.run(1'b1),
				.tick(tick),
				.limit(st_limit),
				.done(st_done)
			);

			// Time spent in current limit while on
			delay_counter #(.W(TW)) u_oc_timer (
				.pclk(pclk),
				.presetn(presetn),
				.clear(!(state_reg == power_seq_pkg::ST_ON &&
					limit_s[ch])),
				.run(1'b1),
				.tick(tick),
				.limit(limit_ticks),
				.done(oc_done)
			);

			// Arming delay after power good
			delay_counter #(.W(TW)) u_arm_timer (
				.pclk(pclk),
				.presetn(presetn),
				.clear(!(ode_s && pg_reg[ch])),
				.run(1'b1),
				.tick(tick),
				.limit(power_seq_pkg::OPEN_ARM_TICKS),
				.done(armed)
			);

			// Low current must persist for the open delay
			delay_counter #(.W(TW)) u_open_timer (
				.pclk(pclk),
				.presetn(presetn),
				.clear(!(armed && ode_s && open_cur_s[ch] &&
					state_reg == power_seq_pkg::ST_ON)),
				.run(1'b1),
				.tick(tick),
				.limit(power_seq_pkg::OPEN_DELAY_TICKS),
				.done(open_done)
			);

			assign oc_latch_reg[ch] = latch_reg;
		end
	endgenerate

	// Registered pin outputs
	logic [N-1:0] status_next; // Next multiplexed status
	logic fault_next; // Next fault pull-down
	always_comb begin
		status_next = stsel_s ? pg_next : open_next;
		fault_next = (|faulted_next) || !supply_above_reg;
	end

	// Output flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_drive <= '0;
			relay_drive <= '0;
			pg_reg <= '0;
			open_reg <= '0;
			port_status <= '0;
			fault_n_oe <= 1'b0;
		end else begin
			gate_drive <= gate_next;
			relay_drive <= relay_next;
			pg_reg <= pg_next;
			open_reg <= open_next;
			port_status <= status_next;
			fault_n_oe <= fault_next;
		end
	end

	assign fault_n_out = 1'b0;

	// Status word for software
	always_comb begin
		status_word = '0;
		status_word[power_seq_pkg::STAT_PG_LSB +: N] = pg_reg;
		status_word[power_seq_pkg::STAT_OPEN_LSB +: N] = open_reg;
		status_word[power_seq_pkg::STAT_OC_LSB +: N] = oc_latch_reg;
		status_word[power_seq_pkg::STAT_RELAY_LSB +: N] = relay_drive;
		status_word[power_seq_pkg::STAT_GATE_LSB +: N] = gate_drive;
		status_word[power_seq_pkg::STAT_SUPPLY_BIT] = supply_up;
	end
endmodule // quad_port_power_switch_sequencer
`default_nettype wire

// ===== quad_port_power_switch_sequencer_bench.sv
// Self-checking bench for the power switch sequencer
`default_nettype none
module quad_port_power_switch_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TC = 4; // Cycles per tick
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, fault_n_out, fault_n_oe, fault_n, er;
	logic [3:0] sw_cmd = 4'h0, rl_cmd = 4'h0, sreq, rreq, full = 4'h0;
	logic [3:0] lim = 4'h0, bopen = 4'h0, gate, relay, stat;
	logic son = 0, soff = 0, oden = 0, ssel = 1, rty = 1, dhi = 0, dlo = 0;
	int n_mismatch = 0, compares = 0, c;
	int mult[$] = '{99, 49, 24}; // Off multiples per duty mode
	assign fault_n = fault_n_oe ? fault_n_out : 1'h1; // Pull-up
	host_req_model i_host (.pclk(pclk), .sw_cmd(sw_cmd), .rl_cmd(rl_cmd),
		.switch_request(sreq), .relay_request(rreq));
	quad_port_power_switch_sequencer #(.TICK_CYCLES(TC)) i_dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.switch_request(sreq), .relay_request(rreq),
		.switch_full_on(full), .in_current_limit(lim),
		.below_open_current(bopen), .supply_above_on(son),
		.supply_above_off(soff), .open_detect_enable(oden),
		.status_select(ssel), .retry_enable(rty),
		.duty_select_high(dhi), .duty_select_low(dlo),
		.gate_drive(gate), .relay_drive(relay), .port_status(stat),
		.fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe));
	// 100 MHz clock
	initial forever #5 pclk = ~pclk;
	// Value compare
	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// Cycle count compare against a window
	task automatic rng(input string nm, input int lo, hi, v);
		compares++;
		if (v < lo || v > hi) begin
			n_mismatch++;
			$display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, v);
		end
	endtask
	// One APB transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [7:0] a, input int d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Cycles until port 0 gate or relay reaches a level
	task automatic wt(input logic rl, v);
		c = 0;
		while (c < 40000 && (rl ? relay[0] : gate[0]) !== v) begin
			@(negedge pclk);
			c++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic report_and_stop;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		#1000000;
		n_mismatch++;
		report_and_stop;
	end
	// Main sequence
	initial begin
		void'($urandom(32'h9B47));
		cyc(20);
		presetn <= 1;
		cyc(4);
		chk("relay_rst", 32'h0, relay);
		chk("fault_rst", 32'h0, fault_n);
		apb(0, 8'h00, 0);
		chk("timing_rst", 32'h0, rd);
		c = $urandom;
		apb(1, 8'h00, c);
		apb(0, 8'h00, 0);
		chk("timing_rw", 32'(c) & 32'h1F, rd);
		apb(0, 8'h08, 0);
		chk("unmapped", 32'h1, er);
		apb(1, 8'h00, 0);
		son <= 1;
		soff <= 1;
		bopen <= 4'($urandom);
		rl_cmd <= 4'h1;
		sw_cmd <= 4'h1;
		wt(1, 1);
		rng("relay_on", 1, 8, c);
		wt(0, 1);
		rng("gate_on", 254 * TC, 257 * TC + 12, c);
		cyc(1);
		full <= 4'h1;
		cyc(6);
		chk("pg_stat", 32'h1, stat);
		apb(0, 8'h04, 0);
		chk("status", 32'h00111001, rd);
		ssel <= 0;
		cyc(6);
		chk("open_stat", 32'h0, stat);
		ssel <= 1;
		for (int d = 0; d < 3; d++) begin
			cyc(1);
			dlo <= (d == 0);
			dhi <= (d == 1);
			lim <= 4'h1;
			wt(0, 0);
			rng("trip", 63 * TC, 65 * TC + 12, c);
			cyc(4);
			chk("fault_oc", 32'h0, fault_n);
			chk("pg_oc", 32'h0, stat);
			lim <= 4'h0;
			wt(0, 1);
			rng("off", (64 * mult[d] - 1) * TC,
				(64 * mult[d] + 1) * TC + 12, c);
		end
		cyc(1);
		rty <= 0;
		lim <= 4'h1;
		wt(0, 0);
		cyc(2);
		lim <= 4'h0;
		cyc(64 * 24 * TC + 100);
		chk("latched", 32'h0, gate);
		chk("fault_lat", 32'h0, fault_n);
		sw_cmd <= 4'h0;
		cyc(8);
		chk("fault_clr", 32'h1, fault_n);
		sw_cmd <= 4'h1;
		wt(0, 1);
		rng("relatch", 1, 20, c);
		cyc(1);
		bopen <= 4'h1;
		oden <= 1;
		wt(0, 0);
		rng("open_off", 9254 * TC, 9257 * TC + 12, c);
		cyc(1);
		ssel <= 0;
		cyc(6);
		chk("open_flag", 32'h1, stat);
		chk("fault_open", 32'h0, fault_n);
		sw_cmd <= 4'h0;
		cyc(6);
		chk("open_clr", 32'h0, stat);
		ssel <= 1;
		sw_cmd <= 4'h1;
		wt(0, 1);
		cyc(1);
		rl_cmd <= 4'h0;
		wt(0, 0);
		rng("gate_off", 1, 6, c);
		wt(1, 0);
		rng("relay_off", 31 * TC, 33 * TC + 12, c);
		cyc(1);
		rl_cmd <= 4'h1;
		wt(1, 1);
		cyc(1);
		son <= 0;
		soff <= 0;
		wt(1, 0);
		rng("supply_low_lockout_off", 1, 6, c);
		cyc(4);
		chk("fault_supply_low_lockout", 32'h0, fault_n);
		report_and_stop;
	end
endmodule // quad_port_power_switch_sequencer_bench
bind quad_port_power_switch_sequencer quad_seq_chk i_chk (.pclk(pclk),
	.presetn(presetn), .switch_request(switch_request),
	.relay_request(relay_request), .in_current_limit(in_current_limit),
	.supply_above_on(supply_above_on), .supply_above_off(supply_above_off),
	.status_select(status_select), .gate_drive(gate_drive),
	.relay_drive(relay_drive), .port_status(port_status),
	.fault_n_oe(fault_n_oe));
`default_nettype wire

// ===== quad_seq_sva.sv
// Port-level assertion checker for the power switch sequencer
`default_nettype none
module quad_seq_chk (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic [3:0] switch_request, // Switch pins
	input wire logic [3:0] relay_request, // Relay pins
	input wire logic [3:0] in_current_limit, // Limit comparator
	input wire logic supply_above_on, // Above lockout
	input wire logic supply_above_off, // Above lockout less hyst
	input wire logic status_select, // Status mux select
	input wire logic [3:0] gate_drive, // Gate enables
	input wire logic [3:0] relay_drive, // Relay enables
	input wire logic [3:0] port_status, // Status pins
	input wire logic fault_n_oe // Fault pulled low
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Pin lows long enough to pass the synchronisers
	sequence sw_low;
		!switch_request[0] [*4];
	endsequence
	sequence rl_low;
		!relay_request[0] [*4];
	endsequence
	// Gate dropped while limiting with all requests held
	sequence trip;
		$fell(gate_drive[0]) && in_current_limit[0] && switch_request[0]
			&& relay_request[0] && supply_above_off;
	endsequence
	AST_GATE_RELAY: assert property ((gate_drive & ~relay_drive) == 4'h0)
		else $error("gate on without relay");
	AST_SW_LOW: assert property (sw_low |-> !gate_drive[0])
		else $error("gate on with switch request low");
	AST_RL_LOW: assert property (rl_low |-> !gate_drive[0])
		else $error("gate on with relay request low");
	AST_SUPPLY_OFF: assert property (!supply_above_off [*5] |->
		(gate_drive | relay_drive) == 4'h0) else $error("drive in lockout");
	AST_RELAY_ON: assert property ((relay_request[0] &&
		supply_above_on) [*6] |-> relay_drive[0]) else $error("relay late");
	AST_GATE_SETTLE: assert property ($rose(gate_drive[0]) |->
		$past(relay_drive[0], 8) && $past(supply_above_off, 8))
		else $error("gate before relay settle");
	AST_TRIP_FAULT: assert property (trip |-> ##[0:3] fault_n_oe)
		else $error("no fault after trip");
	AST_OFF_HOLD: assert property (trip |=> !gate_drive[0] [*8])
		else $error("gate back too soon");
	AST_STATUS_PG: assert property ((status_select [*5] ##0
		port_status[0]) |-> gate_drive[0]) else $error("good while off");
endmodule // quad_seq_chk
`default_nettype wire
